// file: logic/mfe_pkg.sv
/*
 * Shared constants and types of the metering front end: register map, field
 * positions, reset values, sample rates and the carrier structs.
 * Assumes a single 25 MHz system clock and a byte-serial host that has
 * already been turned into single-cycle register strobes.
 */
// Notes on behaviour
// - Metering logic runs only while the RC oscillator runs and halts when it stops.
// - System-control bit 26 picks voltage gain, 0 for x4 and 1 for x1, reset 0.
// - System-control bits 23:22 pick current gain x32, x16, x4, x1, reset 00.
// - Analog-control-0 bits 9:8 trim global bias and software keeps the default.
// - Analog-control-1 bits 29:28 add 0, 33, 66 or 100 percent Miller capacitance.
// - The voltage converter is off after reset and on only while control bit 29 is 1.
// - The current converter is off after reset and on only while control bit 27 is 1.
// - Exactly one of the two sample streams goes through the delay chain.
// - The phase value is nine-bit two's complement, reset zero, usable -255 to +255.
// - Phase bit 8 set delays voltage samples, clear delays current samples.
// - Control bit 19 picks 3276800 Hz when 0 and 819200 Hz when 1.
// - One step is 0.005 degree at the fast rate and 0.022 degree at the slow rate.
package mfe_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_PHASE = 12'h0f7;
    localparam logic [11:0] REG_SYSCTL = 12'h180;
    localparam logic [11:0] REG_ANA0 = 12'h182;
    localparam logic [11:0] REG_ANA1 = 12'h183;
    localparam int SC_VGAIN = 26;
    localparam int SC_IGAIN_LO = 22;
    localparam int SC_VADC = 29;
    localparam int SC_IADC = 27;
    localparam int SC_RATE = 19;
    localparam int A0_BIAS_LO = 8;
    localparam int A1_MILLER_LO = 28;
    localparam int PHASE_W = 9;
    localparam int PHASE_SIGN = 8;
    localparam logic [31:0] SYSCTL_RST = 32'h0000_0000;
    localparam logic [31:0] ANA0_RST = 32'h0000_0100;
    localparam logic [31:0] ANA1_RST = 32'h0000_0000;
    localparam logic [8:0] PHASE_RST = 9'h000;
    localparam int CLK_HZ = 25000000;
    localparam int FAST_HZ = 3276800;
    localparam int SLOW_HZ = 819200;
    localparam int ACC_W = 26;
    localparam int FAST_GAP = CLK_HZ / FAST_HZ - 1;
    localparam int FIFO_DEPTH = 8;
    localparam int DLY_MAX = 255;

    typedef struct packed {
        logic v_gain_x1;
        logic [1:0] i_gain;
        logic [1:0] bias_trim;
        logic [1:0] miller_trim;
        logic v_adc_en;
        logic i_adc_en;
        logic slow_rate;
    } mfe_cfg_s;

    typedef struct packed {
        logic v;
        logic i;
    } mfe_smp_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } mfe_req_s;
endpackage : mfe_pkg

// file: logic/mfe_top.sv
/*
 * Metering front end: configuration registers, sample-rate strobe, the phase
 * compensating delay chain and an output FIFO towards the metering datapath.
 * Assumes converter bit streams and the oscillator-running level come from
 * pins and are asynchronous; register strobes come from logic on clk_sys.
 */

// ****************************************
// Sample FIFO
// ****************************************
module mfe_fifo
    import mfe_pkg::*;
#(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] in_data, // Word to store.
    input wire logic in_valid, // Word offered.
    output logic in_ready, // Room for a word.
    output logic [WIDTH-1:0] out_data, // Oldest word.
    output logic out_valid, // FIFO holds a word.
    input wire logic out_ready // Consumer takes the word.
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
        $error("FIFO depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] cnt;
    } mfe_fifo_st_s;

    mfe_fifo_st_s r;
    mfe_fifo_st_s nxt;
    logic push;
    logic pop;

    assign in_ready = (r.cnt != (PW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data = r.mem[r.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt = r;
        if (push) begin
            nxt.mem[r.wp] = in_data;
            nxt.wp = r.wp + 1'b1;
        end
        if (pop) begin
            nxt.rp = r.rp + 1'b1;
        end
        nxt.cnt = r.cnt + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    fifo_count_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        r.cnt <= (PW+1)'(DEPTH)) else $error("FIFO count beyond depth");
endmodule : mfe_fifo

// ****************************************
// Front end top
// ****************************************
module mfe_top
    import mfe_pkg::*;
(
    input wire logic clk_sys, // 25 MHz system clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire mfe_req_s req, // Register read or write strobe.
    output logic [31:0] rdata, // Read data, valid the cycle after rd.
    input wire logic osc_running, // RC oscillator is running, pin.
    input wire logic v_bit, // Voltage converter bit stream, pin.
    input wire logic i_bit, // Current converter bit stream, pin.
    output mfe_cfg_s cfg, // Analog gain, trim and enable settings.
    output logic sample_tick, // One-cycle strobe at the sample rate.
    output logic sample_lost, // Pulse when a sample met a full FIFO.
    output mfe_smp_s smp_data, // Phase-aligned sample pair.
    output logic smp_valid, // Sample pair available.
    input wire logic smp_ready // Datapath takes the sample pair.
);
    typedef struct packed {
        logic [31:0] sc;
        logic [31:0] a0;
        logic [31:0] a1;
        logic [PHASE_W-1:0] phase;
        logic [ACC_W-1:0] acc;
        logic [1:0] run_sy;
        logic [1:0] v_sy;
        logic [1:0] i_sy;
        logic [DLY_MAX-1:0] line;
        logic [31:0] rdata;
        logic lost;
    } mfe_top_st_s;

    mfe_top_st_s r;
    mfe_top_st_s nxt;
    logic run;
    logic tick;
    logic fire;
    logic in_ready;
    logic sel_v;
    logic [PHASE_W-1:0] mag;
    logic [ACC_W-1:0] step;
    logic [ACC_W-1:0] sum;
    logic v_in;
    logic i_in;
    logic din;
    logic dly;
    mfe_smp_s smp_in;

    // ****************************************
    // Configuration decode
    // ****************************************
    // voltage gain select.
    assign cfg.v_gain_x1 = r.sc[SC_VGAIN];
    assign cfg.i_gain = r.sc[SC_IGAIN_LO +: 2];
    assign cfg.bias_trim = r.a0[A0_BIAS_LO +: 2];
    assign cfg.miller_trim = r.a1[A1_MILLER_LO +: 2];
    assign cfg.v_adc_en = r.sc[SC_VADC];
    assign cfg.i_adc_en = r.sc[SC_IADC];
    assign cfg.slow_rate = r.sc[SC_RATE];
    assign rdata = r.rdata;
    assign sample_lost = r.lost;

    // ****************************************
    // Sample-rate strobe
    // ****************************************
    // Only the second synchroniser stage is read, never the first.
    assign run = r.run_sy[1];
    assign step = cfg.slow_rate ? ACC_W'(SLOW_HZ) : ACC_W'(FAST_HZ);
    assign sum = r.acc + step;
    assign tick = run && (sum >= ACC_W'(CLK_HZ));
    assign sample_tick = tick;
    assign fire = tick && in_ready;

    // ****************************************
    // Phase compensation
    // ****************************************
    // sign selects stream.
    assign sel_v = r.phase[PHASE_SIGN];
    always_comb begin
        mag = sel_v ? (~r.phase + 1'b1) : r.phase;
        if (mag > PHASE_W'(DLY_MAX)) begin
            mag = PHASE_W'(DLY_MAX);
        end
    end
    // A converter that is off feeds constant zero into the chain.
    assign v_in = r.v_sy[1] && cfg.v_adc_en;
    assign i_in = r.i_sy[1] && cfg.i_adc_en;
    assign din = sel_v ? v_in : i_in;
    assign dly = (mag == '0) ? din : r.line[8'(mag - 1'b1)];
    assign smp_in.v = sel_v ? dly : v_in;
    assign smp_in.i = sel_v ? i_in : dly;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt = r;
        nxt.run_sy = {r.run_sy[0], osc_running};
        nxt.v_sy = {r.v_sy[0], v_bit};
        nxt.i_sy = {r.i_sy[0], i_bit};
        if (run) begin
            nxt.acc = tick ? (sum - ACC_W'(CLK_HZ)) : sum;
        end
        // The chain stalls with the FIFO, so a full FIFO drops samples
        // instead of skewing the two streams against each other.
        if (fire) begin
            nxt.line = {r.line[DLY_MAX-2:0], din};
        end
        nxt.lost = tick && !in_ready;
        if (req.wr) begin
            case (req.addr)
                REG_SYSCTL: nxt.sc = req.wdata;
                REG_ANA0: nxt.a0 = req.wdata;
                REG_ANA1: nxt.a1 = req.wdata;
                REG_PHASE: nxt.phase = req.wdata[PHASE_W-1:0];
                default: nxt.sc = r.sc;
            endcase
        end
        nxt.rdata = '0;
        if (req.rd) begin
            case (req.addr)
                REG_SYSCTL: nxt.rdata = r.sc;
                REG_ANA0: nxt.rdata = r.a0;
                REG_ANA1: nxt.rdata = r.a1;
                REG_PHASE: nxt.rdata = {{(32-PHASE_W){1'b0}}, r.phase};
                default: nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{sc: SYSCTL_RST, a0: ANA0_RST, a1: ANA1_RST, phase: PHASE_RST,
                   default: '0};
        end else begin
            r <= nxt;
        end
    end

    mfe_fifo #(
        .WIDTH($bits(mfe_smp_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_data(smp_in),
        .in_valid(fire),
        .in_ready(in_ready),
        .out_data(smp_data),
        .out_valid(smp_valid),
        .out_ready(smp_ready)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    halt_no_tick_a: assert property (!run |-> !sample_tick)
        else $error("Sample strobe while oscillator stopped");
    vgain_write_a: assert property (req.wr && req.addr == REG_SYSCTL
        |=> cfg.v_gain_x1 == $past(req.wdata[SC_VGAIN]))
        else $error("Voltage gain not taken from write");
    igain_write_a: assert property (req.wr && req.addr == REG_SYSCTL
        |=> cfg.i_gain == $past(req.wdata[23:22]))
        else $error("Current gain not taken from write");
    trims_write_a: assert property (req.wr && req.addr == REG_ANA1
        |=> cfg.miller_trim == $past(req.wdata[29:28]))
        else $error("Miller trim not taken from write");
    vadc_hold_a: assert property (!cfg.v_adc_en && !(req.wr &&
        req.addr == REG_SYSCTL) |=> !cfg.v_adc_en)
        else $error("Voltage converter enabled without write");
    iadc_off_a: assert property (!cfg.i_adc_en && fire |->
        !smp_in.i || (!sel_v && mag != '0))
        else $error("Disabled current converter produced a one");
    phase_mag_a: assert property (mag <= 9'd255)
        else $error("Delay magnitude above 255");
    undelayed_a: assert property (fire && !sel_v |-> smp_in.v == v_in)
        else $error("Voltage stream delayed while bit 8 is clear");
    fast_gap_a: assert property (sample_tick && !cfg.slow_rate
        |=> !sample_tick [*6]) else $error("Fast strobes too close");
    // A switch to the fast rate just after a slow strobe may bring the next
    // strobe within eight cycles, so only strobes at the slow rate count here.
    slow_gap_a: assert property (sample_tick && cfg.slow_rate &&
        $stable(cfg.slow_rate) |=> (!sample_tick || !cfg.slow_rate) [*8])
        else $error("Slow strobes too close");
    unit_delay_a: assert property (fire && mag == 9'd1 &&
        $stable(r.phase) |-> dly == r.line[0])
        else $error("One LSB is not one delay unit");
    phase_write_a: assert property (req.wr && req.addr == REG_PHASE
        |=> r.phase == $past(req.wdata[8:0]))
        else $error("Phase value not taken from write");
    bias_write_a: assert property (req.wr && req.addr == REG_ANA0
        |=> cfg.bias_trim == $past(req.wdata[A0_BIAS_LO +: 2]))
        else $error("Bias trim not taken from write");
    vadc_write_a: assert property (req.wr && req.addr == REG_SYSCTL
        |=> cfg.v_adc_en == $past(req.wdata[SC_VADC]))
        else $error("Voltage converter enable not taken from write");
    iadc_write_a: assert property (req.wr && req.addr == REG_SYSCTL
        |=> cfg.i_adc_en == $past(req.wdata[SC_IADC]))
        else $error("Current converter enable not taken from write");
    vadc_off_a: assert property (!cfg.v_adc_en && fire |->
        !smp_in.v || (sel_v && mag != '0))
        else $error("Disabled voltage converter produced a one");
    rate_write_a: assert property (req.wr && req.addr == REG_SYSCTL
        |=> cfg.slow_rate == $past(req.wdata[SC_RATE]))
        else $error("Rate select not taken from write");
    halt_hold_a: assert property (!run |=> $stable(r.acc))
        else $error("Rate accumulator moved while oscillator stopped");
    chain_hold_a: assert property (!fire |=> $stable(r.line))
        else $error("Delay chain shifted without a stored sample");
    lost_pulse_a: assert property (sample_tick && !in_ready |=> sample_lost)
        else $error("Dropped sample not reported");
    phase_read_a: assert property (req.rd && req.addr == REG_PHASE
        |=> rdata == {23'h0, $past(r.phase)})
        else $error("Phase value not read back");
endmodule : mfe_top

// file: test/mfe_far_side.sv
/*
 * Far-side model: the two converter bit streams and the metering datapath.
 * Assumes the bench sets the converter level and asks for datapath stalls.
 */
module mfe_far_side (
    input wire logic clk_sys, // System clock.
    input wire logic lvl, // Level both converters show.
    input wire logic stall, // Datapath holds off.
    output logic v_bit, // Voltage bit stream.
    output logic i_bit, // Current bit stream.
    output logic smp_ready // Datapath takes a pair.
);
    timeunit 1ns;
    timeprecision 100ps;
    // Both streams move together, so any skew seen later comes from the delay chain.
    // The datapath is sometimes slow even when not stalled.
    always @(posedge clk_sys) begin
        v_bit <= #1 lvl;
        i_bit <= #1 lvl;
        smp_ready <= #1 !stall && ($urandom_range(3) != 0);
    end
endmodule : mfe_far_side

// file: test/metering_front_end_phase_comp_tb_top.sv
/*
 * Self-checking bench of the metering front end: registers, enables, sample
 * rate, phase delay and FIFO back-pressure.
 * Assumes mfe_pkg, mfe_top and the far-side model are compiled first.
 */
module metering_front_end_phase_comp_tb_top import mfe_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst_n, osc_running, v_bit, i_bit, smp_ready, lvl, stall, rd_q = 1'b0;
    logic sample_tick, sample_lost, smp_valid;
    logic [31:0] rdata, sc, a0, a1;
    logic [31:0] exp_q[$];
    logic [8:0] ph;
    logic [8:0] phs[5] = '{9'h000, 9'h003, 9'h1fd, 9'h0ff, 9'h101};
    mfe_req_s req;
    mfe_cfg_s cfg;
    mfe_smp_s smp_data, last_pair, last_diff;
    int fails = 0, num_checks = 0, tick_cnt = 0, lost_cnt = 0, diff_cnt = 0;
    int cyc, e, t0, mag;
    real err, fs;
    always #20 clk_sys = ~clk_sys;
    mfe_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .req(req), .rdata(rdata),
        .osc_running(osc_running), .v_bit(v_bit), .i_bit(i_bit), .cfg(cfg),
        .sample_tick(sample_tick), .sample_lost(sample_lost), .smp_data(smp_data),
        .smp_valid(smp_valid), .smp_ready(smp_ready));
    mfe_far_side far (.clk_sys(clk_sys), .lvl(lvl), .stall(stall), .v_bit(v_bit),
        .i_bit(i_bit), .smp_ready(smp_ready));

    // ****************************************
    // Tasks
    // ****************************************
    function automatic mfe_cfg_s cfg_of(logic [31:0] s, logic [31:0] b, logic [31:0] c);
        return {s[26], s[23:22], b[9:8], c[29:28], s[29], s[27], s[19]};
    endfunction : cfg_of
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(posedge clk_sys);
        #1;
        req.wr = 1'b0;
        // An idle edge keeps the strobe from being lowered and raised in one step.
        @(posedge clk_sys);
        #1;
    endtask : reg_wr
    task automatic reg_rd(input logic [11:0] a, input logic [31:0] d);
        exp_q.push_back(d);
        req.rd = 1'b1;
        req.addr = a;
        @(posedge clk_sys);
        #1;
        req.rd = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : reg_rd
    task automatic wait_ticks(input int n, output int c);
        int s;
        s = tick_cnt;
        c = 0;
        while (tick_cnt < s + n && c < 40 * n + 100) begin
            @(posedge clk_sys);
            #1;
            c++;
        end
        if (tick_cnt < s + n) begin
            fails++;
            $display("MISMATCH at %0t: sample ticks stopped", $time);
            end_of_test();
        end
    endtask : wait_ticks

    // Read data stands one cycle, so it is compared at the edge after the strobe.
    always @(posedge clk_sys) begin
        if (rd_q === 1'b1) check(rdata, exp_q.pop_front());
        rd_q <= req.rd;
        tick_cnt += (sample_tick === 1'b1);
        lost_cnt += (sample_lost === 1'b1);
        if (smp_valid === 1'b1 && smp_ready === 1'b1) begin
            last_pair = smp_data;
            if (smp_data.v !== smp_data.i) begin
                diff_cnt++;
                last_diff = smp_data;
            end
        end
    end

    initial begin
        void'($urandom(57021));
        rst_n = 1'b0;
        req = '0;
        osc_running = 1'b0;
        lvl = 1'b0;
        stall = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        check(32'(cfg), 32'(cfg_of(32'h0, 32'h100, 32'h0)));
        reg_rd(REG_SYSCTL, 32'h0);
        reg_rd(REG_ANA0, 32'h100);
        reg_rd(REG_ANA1, 32'h0);
        reg_rd(REG_PHASE, 32'h0);
        reg_wr(12'h181, 32'hffff_ffff);
        reg_rd(12'h181, 32'h0);
        repeat (4) begin
            sc = $urandom();
            a0 = $urandom();
            a0[9:8] = 2'b01;
            a1 = $urandom();
            err = $urandom_range(42) / 1000.0;
            fs = sc[SC_RATE] ? real'(SLOW_HZ) : real'(FAST_HZ);
            ph = 9'(int'(3011.0 / 2.0 * err * fs / 819200.0));
            if ($urandom_range(1) == 1) ph = -ph;
            reg_wr(REG_SYSCTL, sc);
            reg_wr(REG_ANA0, a0);
            reg_wr(REG_ANA1, a1);
            reg_wr(REG_PHASE, {23'($urandom()), ph});
            check(32'(cfg), 32'(cfg_of(sc, a0, a1)));
            reg_rd(REG_PHASE, {23'h0, ph});
            reg_rd(REG_SYSCTL, sc);
        end
        osc_running = 1'b1;
        for (int r = 0; r < 2; r++) begin
            reg_wr(REG_SYSCTL, {12'h280, 1'(r), 19'h0});
            e = 16 * CLK_HZ / (r == 1 ? SLOW_HZ : FAST_HZ);
            wait_ticks(1, cyc);
            wait_ticks(16, cyc);
            check(32'(cyc >= e - 3 && cyc <= e + 3), 32'h1);
        end
        osc_running = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        t0 = tick_cnt;
        repeat (100) @(posedge clk_sys);
        #1;
        check(tick_cnt - t0, 32'h0);
        osc_running = 1'b1;
        reg_wr(REG_SYSCTL, 32'h2800_0000);
        foreach (phs[k]) begin
            mag = phs[k][8] ? 512 - phs[k] : phs[k];
            lvl = 1'b0;
            reg_wr(REG_PHASE, {23'h0, phs[k]});
            wait_ticks(mag + 12, cyc);
            diff_cnt = 0;
            lvl = 1'b1;
            wait_ticks(mag + 20, cyc);
            check(diff_cnt, mag);
            if (mag > 0) check(32'(last_diff), phs[k][8] ? 32'h1 : 32'h2);
        end
        reg_wr(REG_PHASE, 32'h0);
        for (int m = 0; m < 4; m++) begin
            reg_wr(REG_SYSCTL, {2'b0, m[1], 1'b0, m[0], 27'h0});
            wait_ticks(20, cyc);
            check(32'(last_pair), m);
        end
        stall = 1'b1;
        t0 = lost_cnt;
        wait_ticks(20, cyc);
        check(32'(smp_valid), 32'h1);
        check(32'(lost_cnt - t0 >= 8), 32'h1);
        stall = 1'b0;
        wait_ticks(10, cyc);
        t0 = lost_cnt;
        wait_ticks(20, cyc);
        check(lost_cnt - t0, 32'h0);
        end_of_test();
    end
endmodule : metering_front_end_phase_comp_tb_top
